// File: design/lcm_pkg.sv
// Constants for the per-channel line maintenance control block.
// Assumes a single 100 MHz register clock shared with the host port.
`default_nettype none

package lcm_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] LCM_OFS_MONITOR_SELECT  = 8'h0b;
  localparam logic [7:0] LCM_OFS_DIGITAL_LOOPBK  = 8'h0c;
  localparam logic [7:0] LCM_OFS_LOS_CRITERIA    = 8'h0d;
  localparam logic [7:0] LCM_OFS_AUTO_ALL_ONES   = 8'h0e;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int         LCM_MON_DIR_BIT         = 3;
  localparam int         LCM_MON_IDX_MSB         = 2;
  localparam logic [3:0] LCM_MONITOR_RESET       = 4'h0;
  localparam logic [7:0] LCM_LOOPBK_RESET        = 8'h00;
  localparam logic [7:0] LCM_CRITERIA_RESET      = 8'h00;
  localparam logic [7:0] LCM_AUTO_ONES_RESET     = 8'h00;
  localparam logic [7:0] LCM_READ_UNMAPPED       = 8'h00;

  // ----------------------------------------------------------------
  // Synchroniser depth for pin inputs
  // ----------------------------------------------------------------
  localparam int         LCM_SYNC_STAGES         = 2;

endpackage

`default_nettype wire

// File: design/lcm_maint_ctrl.sv
// Per-channel maintenance control: monitor point select, digital
// loopback, loss-of-signal criteria select and automatic all-ones.
// Assumes the host port is synchronous to clock_i; line pins are not.
`default_nettype none

module lcm_maint_ctrl
  import lcm_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  // Host register port
  input  wire logic [7:0]          host_addr_i,
  input  wire logic                host_wr_i,
  input  wire logic                host_rd_i,
  input  wire logic [7:0]          host_wdata_i,
  output logic      [7:0]          host_rdata_o,
  // Device mode pins
  input  wire logic                e1_mode_i,
  input  wire logic                master_clock_in_i,
  input  wire logic [CHANNELS-1:0] analog_loopback_i,
  // Transmit side pins per channel
  input  wire logic [CHANNELS-1:0] transmit_positive_data_i,
  input  wire logic [CHANNELS-1:0] transmit_negative_data_i,
  input  wire logic [CHANNELS-1:0] transmit_clock_in_i,
  // Recovered line data per channel
  input  wire logic [CHANNELS-1:0] line_positive_data_i,
  input  wire logic [CHANNELS-1:0] line_negative_data_i,
  input  wire logic [CHANNELS-1:0] line_clock_i,
  input  wire logic [CHANNELS-1:0] los_detect_i,
  // Receive side outputs per channel
  output logic      [CHANNELS-1:0] receive_positive_data_o,
  output logic      [CHANNELS-1:0] receive_negative_data_o,
  output logic      [CHANNELS-1:0] receive_clock_o,
  // Detection mode and all-ones outputs
  output logic      [CHANNELS-1:0] los_etsi_mode_o,
  output logic                     los_t1_mode_o,
  output logic      [CHANNELS-1:0] transmit_all_ones_o,
  // Monitor point select, one-hot by channel
  output logic      [CHANNELS-1:0] monitor_tx_sel_o,
  output logic      [CHANNELS-1:0] monitor_rx_sel_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int PINS = 7 * CHANNELS + 2;

  logic [PINS-1:0] pin_meta;
  logic [PINS-1:0] pin_sync;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {e1_mode_i, master_clock_in_i, analog_loopback_i,
                   transmit_positive_data_i, transmit_negative_data_i, transmit_clock_in_i,
                   line_positive_data_i, line_negative_data_i, line_clock_i};
      pin_sync <= pin_meta;
    end
  end

  logic                e1_mode_s;
  logic                mclk_high_s;
  logic [CHANNELS-1:0] analog_loop_s;
  logic [CHANNELS-1:0] tx_pos_s;
  logic [CHANNELS-1:0] tx_neg_s;
  logic [CHANNELS-1:0] tx_clk_s;
  logic [CHANNELS-1:0] line_pos_s;
  logic [CHANNELS-1:0] line_neg_s;
  logic [CHANNELS-1:0] line_clk_s;

  assign {e1_mode_s, mclk_high_s, analog_loop_s, tx_pos_s, tx_neg_s, tx_clk_s,
          line_pos_s, line_neg_s, line_clk_s} = pin_sync;

  // Loss of signal also comes from a pin and gets its own pair.
  logic [CHANNELS-1:0] los_meta;
  logic [CHANNELS-1:0] los_s;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      los_meta <= '0;
      los_s    <= '0;
    end else begin
      los_meta <= los_detect_i;
      los_s    <= los_meta;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [3:0]          monitor_select;
  logic [CHANNELS-1:0] loopback_bits;
  logic [CHANNELS-1:0] criteria_bits;
  logic [CHANNELS-1:0] auto_ones_bits;

  // A write lands on the edge that samples the strobe; unmapped offsets are ignored.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      monitor_select <= LCM_MONITOR_RESET;
      loopback_bits  <= LCM_LOOPBK_RESET[CHANNELS-1:0];
      criteria_bits  <= LCM_CRITERIA_RESET[CHANNELS-1:0];
      auto_ones_bits <= LCM_AUTO_ONES_RESET[CHANNELS-1:0];
    end else if (host_wr_i) begin
      unique case (host_addr_i)
        LCM_OFS_MONITOR_SELECT: monitor_select <= host_wdata_i[3:0];
        LCM_OFS_DIGITAL_LOOPBK: loopback_bits  <= host_wdata_i[CHANNELS-1:0];
        LCM_OFS_LOS_CRITERIA:   criteria_bits  <= host_wdata_i[CHANNELS-1:0];
        LCM_OFS_AUTO_ALL_ONES:  auto_ones_bits <= host_wdata_i[CHANNELS-1:0];
        default: ;
      endcase
    end
  end

  // Read data is registered and valid the cycle after the read strobe.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      host_rdata_o <= LCM_READ_UNMAPPED;
    end else if (host_rd_i) begin
      unique case (host_addr_i)
        LCM_OFS_MONITOR_SELECT: host_rdata_o <= {4'h0, monitor_select};
        LCM_OFS_DIGITAL_LOOPBK: host_rdata_o <= 8'(loopback_bits);
        LCM_OFS_LOS_CRITERIA:   host_rdata_o <= 8'(criteria_bits);
        LCM_OFS_AUTO_ALL_ONES:  host_rdata_o <= 8'(auto_ones_bits);
        default:                host_rdata_o <= LCM_READ_UNMAPPED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Digital loopback routing
  // ----------------------------------------------------------------
  // Loopback swaps the receive source and exempts all-ones from the clock block; loss detection is untouched.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      receive_positive_data_o <= '0;
      receive_negative_data_o <= '0;
      receive_clock_o         <= '0;
    end else begin
      receive_positive_data_o <= (loopback_bits & tx_pos_s) | (~loopback_bits & line_pos_s);
      receive_negative_data_o <= (loopback_bits & tx_neg_s) | (~loopback_bits & line_neg_s);
      receive_clock_o         <= (loopback_bits & tx_clk_s) | (~loopback_bits & line_clk_s);
    end
  end

  // ----------------------------------------------------------------
  // Loss-of-signal detection mode
  // ----------------------------------------------------------------
  // In T1 the criteria bits are kept but not passed on.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      los_etsi_mode_o <= '0;
      los_t1_mode_o   <= 1'b0;
    end else begin
      los_etsi_mode_o <= e1_mode_s ? criteria_bits : '0;
      los_t1_mode_o   <= ~e1_mode_s;
    end
  end

  // ----------------------------------------------------------------
  // Automatic all-ones on loss of signal
  // ----------------------------------------------------------------
  // Both clocks high marks data-recovery or line-driver operation, which
  // blocks the automatic all-ones; a channel in digital loopback keeps it
  // independent of its transmit clock.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      transmit_all_ones_o <= '0;
    end else begin
      for (int ch = 0; ch < CHANNELS; ch++) begin
        transmit_all_ones_o[ch] <= auto_ones_bits[ch] & los_s[ch]
                                   & ~(mclk_high_s & tx_clk_s[ch] & ~loopback_bits[ch]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Monitor point select
  // ----------------------------------------------------------------
  logic                     mon_tx_dir;
  logic [LCM_MON_IDX_MSB:0] mon_index;

  assign mon_tx_dir = monitor_select[LCM_MON_DIR_BIT];
  assign mon_index  = monitor_select[LCM_MON_IDX_MSB:0];

  // Index zero selects nothing, so channel zero is never monitored.
  // A transmitter in analog loopback cannot be monitored either.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      monitor_tx_sel_o <= '0;
      monitor_rx_sel_o <= '0;
    end else begin
      for (int ch = 0; ch < CHANNELS; ch++) begin
        monitor_tx_sel_o[ch] <= mon_tx_dir && (mon_index != '0) && (int'(mon_index) == ch)
                                && !analog_loop_s[ch];
        monitor_rx_sel_o[ch] <= !mon_tx_dir && (mon_index != '0) && (int'(mon_index) == ch);
      end
    end
  end

endmodule

`default_nettype wire

// File: tb/lcm_maint_chk.sv
// Concurrent checks on the maintenance control ports.
// Assumes a bind onto lcm_maint_ctrl.
`default_nettype none
module lcm_maint_chk #(parameter int CHANNELS = 8) (
  // Watched ports
  input wire logic                clock_i,
  input wire logic                rst_i,
  input wire logic [7:0]          host_addr_i,
  input wire logic                host_rd_i,
  input wire logic [7:0]          host_rdata_o,
  input wire logic                e1_mode_i,
  input wire logic [CHANNELS-1:0] los_detect_i,
  input wire logic [CHANNELS-1:0] los_etsi_mode_o,
  input wire logic                los_t1_mode_o,
  input wire logic [CHANNELS-1:0] transmit_all_ones_o,
  input wire logic [CHANNELS-1:0] monitor_tx_sel_o,
  input wire logic [CHANNELS-1:0] monitor_rx_sel_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_tx_zero_idle: assert property (monitor_tx_sel_o[0] == 1'h0)
    else $error("tx monitor on channel zero");
  a_rx_one_hot: assert property ($onehot0(monitor_rx_sel_o))
    else $error("rx monitor not one-hot");
  a_tx_rx_apart: assert property (!(|monitor_tx_sel_o && |monitor_rx_sel_o))
    else $error("tx and rx monitor both set");
  a_t1_no_etsi: assert property (los_t1_mode_o |-> los_etsi_mode_o == '0)
    else $error("criteria used in T1");
  a_t1_follows_pin: assert property (!e1_mode_i [*3] |=> los_t1_mode_o)
    else $error("T1 detection not selected");
  a_ones_need_los: assert property ((los_detect_i == '0) [*3] |=> transmit_all_ones_o == '0)
    else $error("all ones without loss");
  a_unmapped_zero: assert property (host_rd_i && (host_addr_i < 8'h0b || host_addr_i > 8'h0e)
    |=> host_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_rdata_holds: assert property (!host_rd_i |=> $stable(host_rdata_o))
    else $error("read data moved without read");
endmodule
bind lcm_maint_ctrl lcm_maint_chk #(.CHANNELS(CHANNELS)) i_lcm_maint_chk (.clock_i(clock_i), .rst_i(rst_i),
  .host_addr_i(host_addr_i), .host_rd_i(host_rd_i), .host_rdata_o(host_rdata_o), .e1_mode_i(e1_mode_i),
  .los_detect_i(los_detect_i), .los_etsi_mode_o(los_etsi_mode_o), .los_t1_mode_o(los_t1_mode_o),
  .transmit_all_ones_o(transmit_all_ones_o), .monitor_tx_sel_o(monitor_tx_sel_o),
  .monitor_rx_sel_o(monitor_rx_sel_o));
`default_nettype wire

// File: tb/lcm_maint_ctrl_bench.sv
// Self-checking bench for the maintenance control block.
// Assumes the checker binds itself; drives every port directly.
`default_nettype none
module lcm_maint_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, e1 = 1'h1, mclk = 1'h0, t1;
  logic [7:0] addr = 8'h00, wd = 8'h00, al = 8'h00, tp = 8'h00, tn = 8'h00, tc = 8'h00, lp = 8'h00;
  logic [7:0] ln = 8'h00, lc = 8'h00, los = 8'h00, rdata, rp, rn, rc, etsi, ones, mtx, mrx;
  int errors = 0, checks = 0, cyc = 0;
  lcm_maint_ctrl i_lcm_maint_ctrl (.clock_i(clk), .rst_i(rst), .host_addr_i(addr), .host_wr_i(wr),
    .host_rd_i(rd), .host_wdata_i(wd), .host_rdata_o(rdata), .e1_mode_i(e1), .master_clock_in_i(mclk),
    .analog_loopback_i(al), .transmit_positive_data_i(tp), .transmit_negative_data_i(tn),
    .transmit_clock_in_i(tc), .line_positive_data_i(lp), .line_negative_data_i(ln), .line_clock_i(lc),
    .los_detect_i(los), .receive_positive_data_o(rp), .receive_negative_data_o(rn), .receive_clock_o(rc),
    .los_etsi_mode_o(etsi), .los_t1_mode_o(t1), .transmit_all_ones_o(ones), .monitor_tx_sel_o(mtx),
    .monitor_rx_sel_o(mrx));
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    addr = a;
    wd = d;
    wr = 1'h1;
    step(1);
    wr = 1'h0;
    step(1);
  endtask
  task automatic rd_reg(logic [7:0] a, logic [7:0] exp);
    addr = a;
    rd = 1'h1;
    step(1);
    rd = 1'h0;
    check("read data", rdata, exp);
    step(1);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    step(4);
    rst = 1'h0;
    for (int a = 11; a < 15; a++) rd_reg(8'(a), 8'h00);
    wr_reg(8'h05, 8'hff);
    rd_reg(8'h05, 8'h00);
    tp = 8'ha5;
    tn = 8'h5a;
    tc = 8'hff;
    lp = 8'h3c;
    ln = 8'hc3;
    lc = 8'h0f;
    wr_reg(8'h0c, 8'h81);
    step(4);
    check("rx positive", rp, 8'hbd);
    check("rx negative", rn, 8'h42);
    check("rx clock", rc, 8'h8f);
    rd_reg(8'h0c, 8'h81);
    wr_reg(8'h0c, 8'h00);
    wr_reg(8'h0d, 8'h6b);
    check("etsi select", etsi, 8'h6b);
    check("rx positive off", rp, 8'h3c);
    e1 = 1'h0;
    step(4);
    check("etsi in t1", etsi, 8'h00);
    check("t1 mode", {7'h00, t1}, 8'h01);
    e1 = 1'h1;
    tc = 8'h01;
    los = 8'h33;
    wr_reg(8'h0e, 8'h0f);
    step(4);
    check("all ones", ones, 8'h03);
    check("t1 mode off", {7'h00, t1}, 8'h00);
    check("etsi back in e1", etsi, 8'h6b);
    mclk = 1'h1;
    step(4);
    check("all ones one blocked", ones, 8'h02);
    tc = 8'hff;
    step(4);
    check("all ones all blocked", ones, 8'h00);
    wr_reg(8'h0c, 8'h01);
    check("all ones in loopback", ones, 8'h01);
    al = 8'h04;
    for (int i = 0; i < 16; i++) begin
      wr_reg(8'h0b, {4'ha, i[3:0]});
      step(2);
      check("tx monitor", mtx, (i[3] && i[2:0] != 3'h0 && i[2:0] != 3'h2) ? 8'h01 << i[2:0] : 8'h00);
      check("rx monitor", mrx, (!i[3] && i[2:0] != 3'h0) ? 8'h01 << i[2:0] : 8'h00);
      rd_reg(8'h0b, {4'h0, i[3:0]});
    end
    rst = 1'h1;
    step(2);
    rst = 1'h0;
    for (int a = 12; a < 15; a++) rd_reg(8'(a), 8'h00);
    check("tx monitor cleared", mtx, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
